// ==== rtl/ctp_pkg.sv ====
// What this block does
// - Counters three and four chain into one 16-bit up-counter versus 16-bit compare.
// - Unit runs only while the run bit is one.
// - Timer mode counts prescaled clock; on match raise interrupt, clear, keep counting.
// - Compare is unbuffered outside PWM; software leaves it alone while running.
// - Event mode counts falling edges of the event pin; after match resumes.
// - Each event pin phase lasts at least two machine cycles.
// - PWM mode toggles the output flip-flop when count equals duty, keeps counting.
// - PWM overflow toggles the flip-flop again, clears counter, raises interrupt.
// - PWM pin drives the inverse of the output flip-flop in PWM mode; in other modes it is held high.
// - Flip-flop takes the initial bit while stopped; reset clears it to zero.
// - Duty is double-buffered: loads at match interrupt, or at once when stopped.
// - Duty readback keeps the previous value until the next match interrupt.
// - Stopping keeps the pin level; initial bit changes only after stopping.
// - Timer sources: fc/2^11 or fs/2^3, fc/2^7, fc/2^5, fc/2^3.
// - PWM adds fs, fc/2 and fc as sources.
package ctp_pkg;
    // ----------------------------------------
    // Constants
    // ----------------------------------------
    localparam int          CTP_W          = 16;
    localparam int          CTP_DIV_W      = 11;
    localparam logic [15:0] CTP_CNT_RST    = 16'h0000;
    localparam logic [15:0] CTP_DUTY_RST   = 16'h0000;
    localparam logic [15:0] CTP_CMP_RST    = 16'h0000;
    localparam int          CTP_FS_DIV     = 610;
    localparam int          CTP_EVT_MIN_CYC = 2;

    typedef enum logic [1:0] {
        CTP_MODE_TIMER,
        CTP_MODE_EVENT,
        CTP_MODE_PWM,
        CTP_MODE_OFF
    } ctp_mode_t;

    typedef enum logic [2:0] {
        CTP_SRC_DIV11,
        CTP_SRC_DIV7,
        CTP_SRC_DIV5,
        CTP_SRC_DIV3,
        CTP_SRC_FS,
        CTP_SRC_DIV1,
        CTP_SRC_FC,
        CTP_SRC_EXT
    } ctp_src_t;

    typedef struct packed {
        logic      run_bit;
        logic      flipflop_init_bit;
        logic      prescaler_source_select;
        ctp_mode_t mode;
        ctp_src_t  src;
    } ctp_ctrl_t;
endpackage

// ==== rtl/ctp_prescaler.sv ====
module ctp_prescaler #(
    parameter int DIV_W  = ctp_pkg::CTP_DIV_W,
    parameter int FS_DIV = ctp_pkg::CTP_FS_DIV
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Source selection
    input  wire logic                  prescaler_source_select,
    input  wire ctp_pkg::ctp_src_t     src,
    // Tick out
    output logic                       tick
);
    initial begin
        if (DIV_W < 11 || FS_DIV < 16)
            $error("ctp_prescaler: divider too small");
    end

    // ----------------------------------------
    // Dividers
    // ----------------------------------------
    // Low-frequency clock is modelled as an enable from mclk
    logic [DIV_W-1:0] div_reg, div_next;
    logic [15:0]      fs_reg, fs_next;
    logic             fs_tick;
    logic [2:0]       fs8_reg, fs8_next;
    logic             tick_next;

    always_comb begin
        fs_tick  = (fs_reg == 16'(FS_DIV - 1));
        div_next = div_reg + 1'b1;
        fs_next  = fs_tick ? 16'h0000 : fs_reg + 16'h0001;
        fs8_next = fs_tick ? fs8_reg + 3'h1 : fs8_reg;
        case (src)
            ctp_pkg::CTP_SRC_DIV11: tick_next = prescaler_source_select ?
                (fs_tick && fs8_reg == 3'h7) : (div_reg == '1);
            ctp_pkg::CTP_SRC_DIV7:  tick_next = (div_reg[6:0] == 7'h7F);
            ctp_pkg::CTP_SRC_DIV5:  tick_next = (div_reg[4:0] == 5'h1F);
            ctp_pkg::CTP_SRC_DIV3:  tick_next = (div_reg[2:0] == 3'h7);
            ctp_pkg::CTP_SRC_FS:    tick_next = fs_tick;
            ctp_pkg::CTP_SRC_DIV1:  tick_next = div_reg[0];
            ctp_pkg::CTP_SRC_FC:    tick_next = 1'b1;
            default:                tick_next = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            div_reg <= '0;
            fs_reg  <= 16'h0000;
            fs8_reg <= 3'h0;
            tick    <= 1'b0;
        end else begin
            div_reg <= div_next;
            fs_reg  <= fs_next;
            fs8_reg <= fs8_next;
            tick    <= tick_next;
        end
    end
endmodule // ctp_prescaler

// ==== rtl/ctp_timer.sv ====
module ctp_timer (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rst,
    // Control
    input  wire ctp_pkg::ctp_ctrl_t  upper_unit_control,
    // Compare and duty write strobes and data
    input  wire logic                compare_low_byte_we,
    input  wire logic                compare_high_byte_we,
    input  wire logic                duty_low_byte_we,
    input  wire logic                duty_high_byte_we,
    input  wire logic [7:0]          wdata,
    // Event pin
    input  wire logic                event_input_pin,
    // Outputs
    output logic [15:0]              compare_value,
    output logic [15:0]              duty_readback,
    output logic [15:0]              count,
    output logic                     match_interrupt,
    output logic                     pwm_out_pin
);
    // ----------------------------------------
    // Prescaler and event input
    // ----------------------------------------
    logic tick;
    logic ev_s1_reg, ev_s2_reg, ev_s3_reg;

    ctp_prescaler u_pre (
        .mclk                    (mclk),
        .rst                     (rst),
        .prescaler_source_select (upper_unit_control.prescaler_source_select),
        .src                     (upper_unit_control.src),
        .tick                    (tick)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0]  cmp_lo_reg, cmp_lo_next;
    logic [15:0] cmp_reg, cmp_next;
    logic [7:0]  duty_lo_reg, duty_lo_next;
    logic [15:0] duty_buf_reg, duty_buf_next;
    logic [15:0] duty_act_reg, duty_act_next;
    logic [15:0] cnt_reg, cnt_next;
    logic        ff_reg, ff_next;
    logic        irq_next, pin_next;
    logic        run, is_pwm, step, fall, dirty_reg, dirty_next;
    logic        pwm_ext;
    logic        run_d_reg;
    logic        init_d_reg;

    always_comb begin
        run     = upper_unit_control.run_bit;
        is_pwm  = upper_unit_control.mode == ctp_pkg::CTP_MODE_PWM;
        pwm_ext = upper_unit_control.src == ctp_pkg::CTP_SRC_EXT;
        fall    = ev_s3_reg && !ev_s2_reg;
        case (upper_unit_control.mode)
            ctp_pkg::CTP_MODE_TIMER: step = tick;
            ctp_pkg::CTP_MODE_EVENT: step = fall;
            ctp_pkg::CTP_MODE_PWM:   step = pwm_ext ? fall : tick;
            default:                 step = 1'b0;
        endcase
        step = step && run;

        // Compare is unbuffered: high byte write completes the word
        cmp_lo_next = compare_low_byte_we ? wdata : cmp_lo_reg;
        cmp_next    = compare_high_byte_we ? {wdata, cmp_lo_reg} : cmp_reg;
        duty_lo_next  = duty_low_byte_we ? wdata : duty_lo_reg;
        duty_buf_next = duty_high_byte_we ? {wdata, duty_lo_reg}
                                          : duty_buf_reg;
        dirty_next    = dirty_reg || duty_high_byte_we;

        cnt_next      = cnt_reg;
        ff_next       = ff_reg;
        irq_next      = 1'b0;
        duty_act_next = duty_act_reg;

        if (!run) begin
            cnt_next = ctp_pkg::CTP_CNT_RST;
            if (dirty_next) begin
                duty_act_next = duty_buf_next;
                dirty_next    = 1'b0;
            end
            // Pin holds level on stop; only a later change of the init
            // bit reloads the flip-flop, so the stopping write cannot
            if (!run_d_reg && upper_unit_control.flipflop_init_bit
                    != init_d_reg)
                ff_next = upper_unit_control.flipflop_init_bit;
        end else if (step) begin
            if (is_pwm) begin
                cnt_next = cnt_reg + 16'h0001;
                if (cnt_reg == 16'hFFFF) begin
                    ff_next  = !ff_reg;
                    irq_next = 1'b1;
                    if (dirty_reg) begin
                        duty_act_next = duty_buf_reg;
                        dirty_next    = duty_high_byte_we;
                    end
                end else if (cnt_reg == duty_act_reg) begin
                    ff_next = !ff_reg;
                end
            end else if (cnt_reg == cmp_reg) begin
                cnt_next = ctp_pkg::CTP_CNT_RST;
                irq_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
        pin_next = is_pwm ? !ff_next : 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ev_s1_reg    <= 1'b1;
            ev_s2_reg    <= 1'b1;
            ev_s3_reg    <= 1'b1;
            cmp_lo_reg   <= 8'h00;
            cmp_reg      <= ctp_pkg::CTP_CMP_RST;
            duty_lo_reg  <= 8'h00;
            duty_buf_reg <= ctp_pkg::CTP_DUTY_RST;
            duty_act_reg <= ctp_pkg::CTP_DUTY_RST;
            dirty_reg    <= 1'b0;
            cnt_reg      <= ctp_pkg::CTP_CNT_RST;
            ff_reg       <= 1'b0;
            match_interrupt <= 1'b0;
            pwm_out_pin  <= 1'b1;
            run_d_reg    <= 1'b0;
            init_d_reg   <= 1'b0;
        end else begin
            ev_s1_reg    <= event_input_pin;
            ev_s2_reg    <= ev_s1_reg;
            ev_s3_reg    <= ev_s2_reg;
            cmp_lo_reg   <= cmp_lo_next;
            cmp_reg      <= cmp_next;
            duty_lo_reg  <= duty_lo_next;
            duty_buf_reg <= duty_buf_next;
            duty_act_reg <= duty_act_next;
            dirty_reg    <= dirty_next;
            cnt_reg      <= cnt_next;
            ff_reg       <= ff_next;
            match_interrupt <= irq_next;
            pwm_out_pin  <= pin_next;
            run_d_reg    <= upper_unit_control.run_bit;
            init_d_reg   <= upper_unit_control.flipflop_init_bit;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            compare_value <= 16'h0000;
            duty_readback <= 16'h0000;
            count         <= 16'h0000;
        end else begin
            compare_value <= cmp_next;
            duty_readback <= duty_act_next;
            count         <= cnt_next;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_stop_clears;
        @(posedge mclk) disable iff (rst)
        !upper_unit_control.run_bit |=> cnt_reg == 16'h0000;
    endproperty
    a_stop_clears: assert property (p_stop_clears)
        else $error("counter not cleared while stopped");

    property p_timer_match;
        @(posedge mclk) disable iff (rst)
        run && step && !is_pwm && cnt_reg == cmp_reg
            |=> match_interrupt && cnt_reg == 16'h0000;
    endproperty
    a_timer_match: assert property (p_timer_match)
        else $error("match did not clear and interrupt");

    property p_pwm_overflow;
        @(posedge mclk) disable iff (rst)
        run && step && is_pwm && cnt_reg == 16'hFFFF
            |=> match_interrupt && ff_reg != $past(ff_reg);
    endproperty
    a_pwm_overflow: assert property (p_pwm_overflow)
        else $error("overflow did not toggle");

    property p_pin_inverse;
        @(posedge mclk) disable iff (rst)
        is_pwm && $past(is_pwm) |-> pwm_out_pin == !ff_reg;
    endproperty
    a_pin_inverse: assert property (p_pin_inverse)
        else $error("pin not inverse of flip-flop");

    property p_no_run_no_irq;
        @(posedge mclk) disable iff (rst)
        !run |=> !match_interrupt;
    endproperty
    a_no_run_no_irq: assert property (p_no_run_no_irq)
        else $error("interrupt while stopped");

    property p_duty_toggle;
        @(posedge mclk) disable iff (rst)
        run && step && is_pwm && cnt_reg == duty_act_reg
            && cnt_reg != 16'hFFFF |=> ff_reg != $past(ff_reg);
    endproperty
    a_duty_toggle: assert property (p_duty_toggle)
        else $error("duty match did not toggle");

    property p_duty_held;
        @(posedge mclk) disable iff (rst)
        run && !match_interrupt ##1 run && !match_interrupt
            |-> $stable(duty_act_reg);
    endproperty
    a_duty_held: assert property (p_duty_held)
        else $error("duty changed between interrupts");

    property p_event_count;
        @(posedge mclk) disable iff (rst)
        run && upper_unit_control.mode == ctp_pkg::CTP_MODE_EVENT && !fall
            |=> $stable(cnt_reg);
    endproperty
    a_event_count: assert property (p_event_count)
        else $error("event counter moved without edge");

    c_timer_irq: cover property (@(posedge mclk) !is_pwm && match_interrupt);
    c_pwm_irq:   cover property (@(posedge mclk) is_pwm && match_interrupt);
    c_stop:      cover property (@(posedge mclk) run_d_reg && !run);
endmodule // ctp_timer

// ==== bench/ctp_partner.sv ====
module ctp_partner (
    // Clock
    input  wire logic mclk,
    // Event pin, idles high
    output logic      event_input_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Pulse source
    // ----------------------------------------
    initial event_input_pin = 1'b1;

    // Three cycles a phase, above the two-cycle floor
    task automatic pulse(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (3) @(posedge mclk);
            event_input_pin <= 1'b0;
            repeat (3) @(posedge mclk);
            event_input_pin <= 1'b1;
        end
        // Room for the pin synchroniser to settle
        repeat (6) @(posedge mclk);
    endtask
endmodule // ctp_partner

// ==== bench/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic               mclk;
    logic               rst;
    ctp_pkg::ctp_ctrl_t ctrl;
    logic               cl_we, ch_we, dl_we, dh_we;
    logic [7:0]         wdata;
    logic               evt;
    logic [15:0]        cmp_v, duty_v, cnt;
    logic               irq, pwm;
    int                 error_cnt, compares, cyc, t0, p;
    ctp_pkg::ctp_src_t  srcs [4];
    int                 lens [4];

    ctp_timer dut (.mclk(mclk), .rst(rst), .upper_unit_control(ctrl),
        .compare_low_byte_we(cl_we), .compare_high_byte_we(ch_we),
        .duty_low_byte_we(dl_we), .duty_high_byte_we(dh_we),
        .wdata(wdata), .event_input_pin(evt), .compare_value(cmp_v),
        .duty_readback(duty_v), .count(cnt), .match_interrupt(irq),
        .pwm_out_pin(pwm));
    ctp_partner u_src (.mclk(mclk), .event_input_pin(evt));

    // ----------------------------------------
    // Clock, timeout and checks
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic summarize;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Ceiling covers the full 16-bit PWM period plus the timer sweep
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 95000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic check16(input string name, input logic [15:0] e,
                           input logic [15:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", name, e, g);
        end
    endtask

    task automatic check1(input string name, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %b got %b", name, e, g);
        end
    endtask

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic wr16(input logic duty, input logic [15:0] v);
        @(posedge mclk);
        cl_we <= !duty;
        dl_we <= duty;
        wdata <= v[7:0];
        @(posedge mclk);
        cl_we <= 1'b0;
        dl_we <= 1'b0;
        ch_we <= !duty;
        dh_we <= duty;
        wdata <= v[15:8];
        @(posedge mclk);
        ch_we <= 1'b0;
        dh_we <= 1'b0;
        @(posedge mclk);
        #1;
    endtask

    task automatic set_ctrl(input logic run, input logic init,
                            input ctp_pkg::ctp_mode_t m,
                            input ctp_pkg::ctp_src_t s);
        @(posedge mclk);
        ctrl <= '{run_bit: run, flipflop_init_bit: init,
                  prescaler_source_select: 1'b0, mode: m, src: s};
        repeat (2) @(posedge mclk);
        #1;
    endtask

    // Waits for the match pulse; the counter must read zero with it
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        @(posedge mclk);
        #1;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check1("irq_seen", 1'b1, irq);
        check16("cnt_clr", 16'h0000, cnt);
    endtask

    task automatic wait_cnt(input logic [15:0] v);
        int n;
        n = 0;
        while (cnt !== v && n < 70000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check16("cnt_reach", v, cnt);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        ctrl = '0;
        {cl_we, ch_we, dl_we, dh_we} = 4'h0;
        wdata = 8'h00;
        srcs = '{ctp_pkg::CTP_SRC_DIV11, ctp_pkg::CTP_SRC_DIV7,
                 ctp_pkg::CTP_SRC_DIV5, ctp_pkg::CTP_SRC_DIV3};
        lens = '{2048, 128, 32, 8};
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        check16("cmp_rst", 16'h0000, cmp_v);
        check16("cnt_rst", 16'h0000, cnt);
        check1("pin_rst", 1'b1, pwm);
        wr16(1'b0, 16'hA501);
        check16("cmp_word", 16'hA501, cmp_v);
        wr16(1'b0, 16'h0001);
        // Init bit held low outside PWM
        for (int k = 0; k < 4; k++) begin
            set_ctrl(1'b1, 1'b0, ctp_pkg::CTP_MODE_TIMER, srcs[k]);
            wait_irq(5000);
            t0 = cyc;
            wait_irq(5000);
            p = cyc - t0;
            check1("tmr_period", 1'b1, p % lens[k] == 0 && p >= lens[k]
                   && p <= 2 * lens[k]);
            set_ctrl(1'b0, 1'b0, ctp_pkg::CTP_MODE_TIMER, srcs[k]);
            check16("cnt_stop", 16'h0000, cnt);
        end
        wr16(1'b0, 16'h0003);
        set_ctrl(1'b1, 1'b0, ctp_pkg::CTP_MODE_EVENT, ctp_pkg::CTP_SRC_EXT);
        u_src.pulse(2);
        check16("evt_cnt", 16'h0002, cnt);
        fork
            u_src.pulse(2);
            wait_irq(60);
        join
        u_src.pulse(1);
        check16("evt_resume", 16'h0001, cnt);
        set_ctrl(1'b0, 1'b0, ctp_pkg::CTP_MODE_PWM, ctp_pkg::CTP_SRC_FC);
        set_ctrl(1'b0, 1'b1, ctp_pkg::CTP_MODE_PWM, ctp_pkg::CTP_SRC_FC);
        check1("pin_init1", 1'b0, pwm);
        set_ctrl(1'b0, 1'b0, ctp_pkg::CTP_MODE_PWM, ctp_pkg::CTP_SRC_FC);
        check1("pin_init0", 1'b1, pwm);
        wr16(1'b1, 16'h0010);
        check16("duty_stop", 16'h0010, duty_v);
        set_ctrl(1'b1, 1'b0, ctp_pkg::CTP_MODE_PWM, ctp_pkg::CTP_SRC_FC);
        wait_cnt(16'h0020);
        check1("pin_duty", 1'b0, pwm);
        wr16(1'b1, 16'h0100);
        check16("duty_read", 16'h0010, duty_v);
        wait_irq(70000);
        check16("duty_shift", 16'h0100, duty_v);
        check1("pin_ovf", 1'b1, pwm);
        wait_cnt(16'h0080);
        check1("pin_old", 1'b1, pwm);
        wait_cnt(16'h0110);
        check1("pin_new", 1'b0, pwm);
        set_ctrl(1'b0, 1'b0, ctp_pkg::CTP_MODE_PWM, ctp_pkg::CTP_SRC_FC);
        check1("pin_hold", 1'b0, pwm);
        check16("cnt_pwm_stop", 16'h0000, cnt);
        summarize();
    end
endmodule // tb
